// File: core/adcseq_pkg.sv
/*
  adcseq_pkg: register offsets, field positions, reset values and timing
  counts for the converter sequencer.
  assumes: 32-bit APB, one register per aligned word.
*/
package adcseq_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADCSEQ_CTRL0_OFS = 8'h00;
  localparam logic [7:0] ADCSEQ_CTRL1_OFS = 8'h04;
  localparam logic [7:0] ADCSEQ_RESL_OFS = 8'h08;
  localparam logic [7:0] ADCSEQ_RESH_OFS = 8'h0c;
  localparam logic [7:0] ADCSEQ_FLAG_OFS = 8'h10;
  localparam logic [7:0] ADCSEQ_PORT_OFS = 8'h14;
  // ----------------------------------------
  // control 0 fields: on, go, channel select
  // ----------------------------------------
  localparam int ADCSEQ_ON_BIT = 0;
  localparam int ADCSEQ_GO_BIT = 2;
  localparam int ADCSEQ_CHS_LSB = 4;
  // ----------------------------------------
  // control 1 fields: port config, justify, clock select
  // ----------------------------------------
  localparam int ADCSEQ_PCFG_LSB = 1;
  localparam int ADCSEQ_JUST_BIT = 5;
  localparam int ADCSEQ_CS_LSB = 6;
  // ----------------------------------------
  // flag register fields
  // ----------------------------------------
  localparam int ADCSEQ_DONE_BIT = 0;
  localparam int ADCSEQ_IRQEN_BIT = 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ADCSEQ_CTRL0_RST = 8'h00;
  localparam logic [7:0] ADCSEQ_CTRL1_RST = 8'h00;
  // ----------------------------------------
  // clock select codes and bit period lengths
  // ----------------------------------------
  localparam logic [1:0] ADCSEQ_CS_DIV8 = 2'h0;
  localparam logic [1:0] ADCSEQ_CS_DIV32 = 2'h1;
  localparam logic [1:0] ADCSEQ_CS_DIV64 = 2'h2;
  localparam logic [1:0] ADCSEQ_CS_RC = 2'h3;
  localparam int ADCSEQ_TOSC_DIV8 = 8;
  localparam int ADCSEQ_TOSC_DIV32 = 32;
  localparam int ADCSEQ_TOSC_DIV64 = 64;
  // ----------------------------------------
  // conversion timing in bit periods
  // ----------------------------------------
  localparam int ADCSEQ_RES_BITS = 10;
  localparam int ADCSEQ_CONV_TAD = 12;
  localparam int ADCSEQ_HOLD_TAD = 2;
  // instruction cycle is four oscillator periods
  localparam int ADCSEQ_TCY_TOSC = 4;
endpackage

// File: core/adcseq_tad_gen.sv
/*
  adcseq_tad_gen: bit period tick generator for the conversion sequencer.
  assumes: rc_tick is already synchronous to the oscillator clock.
*/
`timescale 1ns/1ps
module adcseq_tad_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic rc_tick,
  // bit period tick
  output logic tick
);
  import adcseq_pkg::*;

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic [6:0] last;
  wire wrap = (cnt_ff == last);

  // period minus one for each oscillator divide
  assign last = (sel == ADCSEQ_CS_DIV8) ? 7'(ADCSEQ_TOSC_DIV8 - 1) :
                (sel == ADCSEQ_CS_DIV32) ? 7'(ADCSEQ_TOSC_DIV32 - 1) : 7'(ADCSEQ_TOSC_DIV64 - 1);
  assign nxt_cnt = (!run || wrap) ? 7'h00 : cnt_ff + 7'h01;
  assign tick = run && ((sel == ADCSEQ_CS_RC) ? rc_tick : wrap);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// File: core/adcseq_top.sv
/*
  adcseq_top: control of a 10-bit successive-approximation converter with
  an APB register file, bit clock select, abort, justification and sleep.
  assumes: REF_CLK is the oscillator; RC_CLK_PIN is a slow free-running
  internal RC clock seen as a level and synchronised here; the comparator
  answer settles within one bit period; sleep comes from the core.
*/
// Notes on behaviour
// - a conversion lasts twelve bit periods.
// - clock select 00/01/10 give 8/32/64 oscillator periods, 11 the RC.
// - port reads return zero on analog configured pins.
// - the multiplexer converts a selected pin even if digital.
// - clearing go aborts; result pair keeps its old value.
// - after abort wait one to two bit periods, then acquire again.
// - first segment after go lasts one instruction cycle to one bit period.
// - result is loaded left or right justified, zero filled.
// - while disabled the result bytes are plain read/write storage.
// - at completion go clears and the done flag sets.
// - sleep conversion only with the RC clock selected.
// - with RC clock, wait one instruction cycle after go.
// - sleep completion wakes if enabled, else powers down, on bit kept.
// - sleep with non-RC clock aborts and powers down, on bit kept.
// - after completion hold two bit periods before acquisition.
// - reset clears the registers, turns off and aborts.
`timescale 1ns/1ps
module adcseq_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // core side
  input wire logic SLEEP_REQ,
  input wire logic [15:0] PORT_PIN_LEVEL,
  input wire logic RC_CLK_PIN,
  output logic WAKE,
  // analog side
  input wire logic COMPARATOR_HIGH,
  output logic [3:0] CHANNEL_SELECT,
  output logic SAMPLE_CONNECT,
  output logic ANALOG_POWER,
  output logic [9:0] DAC_CODE
);
  import adcseq_pkg::*;

  typedef enum {
    ADCSEQ_IDLE, ADCSEQ_FIRST, ADCSEQ_CONV, ADCSEQ_HOLD
  } adcseq_state_t;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic on_ff, go_ff, just_ff, done_ff, irqen_ff, pwrdn_ff, wake_ff;
  logic [3:0] chs_ff;
  logic [2:0] pcfg_ff;
  logic pcfg0_ff;
  logic [1:0] cs_ff;
  logic [7:0] resl_ff, resh_ff;
  logic [9:0] sar_ff, trial_ff;
  logic [3:0] bits_ff;
  logic [1:0] hold_ff;
  logic [1:0] tcy_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [15:0] pin_s1_ff, pin_s2_ff;
  logic cmp_s1_ff, cmp_s2_ff;
  logic rc_s1_ff, rc_s2_ff, rc_s3_ff;
  logic sleep_s1_ff, sleep_s2_ff;
  adcseq_state_t state_ff, nxt_state;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one wait state: setup, access with pready low, then pready high
  wire acc = PSEL && PENABLE && !pready_ff;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire hit_c0 = (PADDR == ADCSEQ_CTRL0_OFS);
  wire hit_c1 = (PADDR == ADCSEQ_CTRL1_OFS);
  wire hit_rl = (PADDR == ADCSEQ_RESL_OFS);
  wire hit_rh = (PADDR == ADCSEQ_RESH_OFS);
  wire hit_fl = (PADDR == ADCSEQ_FLAG_OFS);
  wire hit_pt = (PADDR == ADCSEQ_PORT_OFS);
  wire mapped = hit_c0 || hit_c1 || hit_rl || hit_rh || hit_fl || hit_pt;
  wire wr_c0 = wr && hit_c0;
  wire wr_go = wr_c0 && PWDATA[ADCSEQ_GO_BIT];
  wire wr_go_clr = wr_c0 && !PWDATA[ADCSEQ_GO_BIT];
  wire wr_on = PWDATA[ADCSEQ_ON_BIT];

  // ----------------------------------------
  // synchronisers and tick sources
  // ----------------------------------------
  wire sleeping = sleep_s2_ff;
  wire rc_sel = (cs_ff == ADCSEQ_CS_RC);
  wire rc_tick = rc_s2_ff && !rc_s3_ff;
  wire busy = (state_ff != ADCSEQ_IDLE);
  wire tick;

  adcseq_tad_gen u_tad (
    .clk(REF_CLK),
    .rst(RESET),
    .run(busy),
    .sel(cs_ff),
    .rc_tick(rc_tick),
    .tick(tick)
  );

  // ----------------------------------------
  // analog pin map: in each byte, pins at or above the config threshold go digital
  // ----------------------------------------
  logic [15:0] analog_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_map
      assign analog_mask[gi] = (gi < 7 - pcfg_ff) || (pcfg_ff == 3'h0);
      assign analog_mask[gi + 8] = (gi < 7 - pcfg_ff) || (pcfg_ff == 3'h0);
    end
  endgenerate
  wire [15:0] port_read = pin_s2_ff & ~analog_mask;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // sleep with an oscillator clock kills the conversion
  wire sleep_abort = sleeping && !rc_sel && busy && go_ff;
  wire abort = (wr_go_clr && go_ff && busy) || sleep_abort;
  // first segment: one instruction cycle with RC, else until first tick
  wire first_done = rc_sel ? (tcy_ff == 2'(ADCSEQ_TCY_TOSC - 1)) : tick;
  wire last_bit = (bits_ff == 4'h0);
  wire finish = (state_ff == ADCSEQ_CONV) && tick && last_bit && go_ff;
  wire [9:0] result = sar_ff | (cmp_s2_ff ? trial_ff : 10'h000);
  wire start = wr_go && on_ff && !busy && (!sleeping || rc_sel);
  // oscillator clocks stop converting in sleep
  wire may_run = !sleeping || rc_sel;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADCSEQ_IDLE: if (start && may_run) nxt_state = ADCSEQ_FIRST;
      ADCSEQ_FIRST: if (abort) nxt_state = ADCSEQ_HOLD;
        else if (first_done) nxt_state = ADCSEQ_CONV;
      ADCSEQ_CONV: if (abort || finish) nxt_state = ADCSEQ_HOLD;
      ADCSEQ_HOLD: if (tick && hold_ff == 2'(ADCSEQ_HOLD_TAD - 1)) nxt_state = ADCSEQ_IDLE;
      default: nxt_state = ADCSEQ_IDLE;
    endcase
    if (!on_ff) nxt_state = ADCSEQ_IDLE;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_ff <= ADCSEQ_IDLE;
      sar_ff <= 10'h000;
      trial_ff <= 10'h000;
      bits_ff <= 4'h0;
      hold_ff <= 2'h0;
      tcy_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      tcy_ff <= (state_ff == ADCSEQ_FIRST) ? tcy_ff + 2'h1 : 2'h0;
      hold_ff <= (state_ff != ADCSEQ_HOLD) ? 2'h0 : (tick ? hold_ff + 2'h1 : hold_ff);
      if (state_ff == ADCSEQ_FIRST) begin
        sar_ff <= 10'h000;
        trial_ff <= 10'h200;
        // twelve periods: first segment, ten decisions, one more to load
        bits_ff <= 4'(ADCSEQ_CONV_TAD - 2);
      end else if (state_ff == ADCSEQ_CONV && tick) begin
        // msb first, one decision per period
        if (bits_ff > 4'(ADCSEQ_CONV_TAD - 2 - ADCSEQ_RES_BITS)) begin
          sar_ff <= result;
          trial_ff <= trial_ff >> 1;
        end
        bits_ff <= bits_ff - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // control and result registers
  // ----------------------------------------
  wire [15:0] packed_res = just_ff ? {6'h00, sar_ff} : {sar_ff, 6'h00};

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      on_ff <= ADCSEQ_CTRL0_RST[ADCSEQ_ON_BIT];
      go_ff <= ADCSEQ_CTRL0_RST[ADCSEQ_GO_BIT];
      chs_ff <= ADCSEQ_CTRL0_RST[ADCSEQ_CHS_LSB +: 4];
      pcfg0_ff <= ADCSEQ_CTRL1_RST[0];
      pcfg_ff <= ADCSEQ_CTRL1_RST[ADCSEQ_PCFG_LSB +: 3];
      just_ff <= ADCSEQ_CTRL1_RST[ADCSEQ_JUST_BIT];
      cs_ff <= ADCSEQ_CTRL1_RST[ADCSEQ_CS_LSB +: 2];
      done_ff <= 1'b0;
      irqen_ff <= 1'b0;
      pwrdn_ff <= 1'b0;
      wake_ff <= 1'b0;
      resl_ff <= 8'h00;
      resh_ff <= 8'h00;
    end else begin
      if (wr_c0) begin
        on_ff <= wr_on;
        chs_ff <= PWDATA[ADCSEQ_CHS_LSB +: 4];
      end
      // go sets only if already on and idle
      if (finish || abort || (wr_c0 && !wr_on)) begin
        go_ff <= 1'b0;
      end else if (start) begin
        go_ff <= 1'b1;
      end
      if (wr && hit_c1) begin
        pcfg0_ff <= PWDATA[0];
        pcfg_ff <= PWDATA[ADCSEQ_PCFG_LSB +: 3];
        just_ff <= PWDATA[ADCSEQ_JUST_BIT];
        cs_ff <= PWDATA[ADCSEQ_CS_LSB +: 2];
      end
      if (wr && hit_fl) begin
        irqen_ff <= PWDATA[ADCSEQ_IRQEN_BIT];
      end
      // set wins over a software clear
      if (finish) begin
        done_ff <= 1'b1;
      end else if (wr && hit_fl) begin
        done_ff <= PWDATA[ADCSEQ_DONE_BIT];
      end
      // result pair loaded only on completion
      if (finish) begin
        resl_ff <= packed_res[7:0];
        resh_ff <= packed_res[15:8];
      end else begin
        // plain storage while off
        if (wr && hit_rl) resl_ff <= PWDATA[7:0];
        if (wr && hit_rh) resh_ff <= PWDATA[7:0];
      end
      if (!on_ff || !sleeping) begin
        pwrdn_ff <= 1'b0;
      end else if (!rc_sel || (finish && !irqen_ff)) begin
        pwrdn_ff <= 1'b1;
      end
      wake_ff <= finish && irqen_ff && sleeping;
    end
  end

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  wire [31:0] rd_c0 = {24'h0, chs_ff, 1'b0, go_ff, 1'b0, on_ff};
  wire [31:0] rd_c1 = {24'h0, cs_ff, just_ff, 1'b0, pcfg_ff, pcfg0_ff};
  wire [31:0] rd_fl = {30'h0, irqen_ff, done_ff};
  wire [31:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 : hit_rl ? {24'h0, resl_ff} :
                       hit_rh ? {24'h0, resh_ff} : hit_fl ? rd_fl :
                       hit_pt ? {16'h0, port_read} : 32'h0;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && !mapped;
      prdata_ff <= rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pin_s1_ff <= 16'h0;
      pin_s2_ff <= 16'h0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
      sleep_s1_ff <= 1'b0;
      sleep_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= PORT_PIN_LEVEL;
      pin_s2_ff <= pin_s1_ff;
      cmp_s1_ff <= COMPARATOR_HIGH;
      cmp_s2_ff <= cmp_s1_ff;
      rc_s1_ff <= RC_CLK_PIN;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
      sleep_s1_ff <= SLEEP_REQ;
      sleep_s2_ff <= sleep_s1_ff;
    end
  end

  // ----------------------------------------
  // analog outputs, all registered
  // ----------------------------------------
  logic [3:0] chsel_ff;
  logic samp_ff, apwr_ff;
  logic [9:0] dac_ff;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      chsel_ff <= 4'h0;
      samp_ff <= 1'b0;
      apwr_ff <= 1'b0;
      dac_ff <= 10'h000;
    end else begin
      // selection ignores pin direction and digital config
      chsel_ff <= chs_ff;
      // capacitor tracks only when idle and powered
      samp_ff <= on_ff && !pwrdn_ff && (nxt_state == ADCSEQ_IDLE);
      apwr_ff <= on_ff && !pwrdn_ff;
      dac_ff <= sar_ff | trial_ff;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign WAKE = wake_ff;
  assign CHANNEL_SELECT = chsel_ff;
  assign SAMPLE_CONNECT = samp_ff;
  assign ANALOG_POWER = apwr_ff;
  assign DAC_CODE = dac_ff;
endmodule

// File: verification/adcseq_monitor.sv
/*
  adcseq_monitor: port-level assertions for adcseq_top.
  assumes: bound to adcseq_top; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module adcseq_monitor
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // core and analog side
  input wire logic SLEEP_REQ,
  input wire logic WAKE,
  input wire logic [3:0] CHANNEL_SELECT,
  input wire logic SAMPLE_CONNECT,
  input wire logic ANALOG_POWER,
  input wire logic [9:0] DAC_CODE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // shadow of written fields
  // ----------------------------------------
  logic [1:0] cs_ff;
  logic [3:0] chs_ff;
  wire wr_take = PSEL && PENABLE && !PREADY && PWRITE;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cs_ff <= 2'h0;
      chs_ff <= 4'h0;
    end else begin
      if (wr_take && PADDR == ADCSEQ_CTRL1_OFS) cs_ff <= PWDATA[ADCSEQ_CS_LSB +: 2];
      if (wr_take && PADDR == ADCSEQ_CTRL0_OFS) chs_ff <= PWDATA[ADCSEQ_CHS_LSB +: 4];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_wr_ctrl0;
    wr_take && PADDR == ADCSEQ_CTRL0_OFS;
  endsequence
  // five edges covers the two-flop sync plus the power-down register and the registered power output
  sequence s_osc_sleep;
    (SLEEP_REQ && cs_ff != ADCSEQ_CS_RC) [*5];
  endsequence
  property p_wait_state; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  property p_err_qual; PSLVERR |-> PREADY; endproperty
  property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  property p_reset_clear;
    $fell(RESET) |-> !ANALOG_POWER && !SAMPLE_CONNECT && !WAKE && DAC_CODE == 10'h0 && CHANNEL_SELECT == 4'h0;
  endproperty
  property p_hold_min; $fell(SAMPLE_CONNECT) |=> !SAMPLE_CONNECT [*2]; endproperty
  property p_no_sample_unpowered; !ANALOG_POWER ##1 !ANALOG_POWER |-> !SAMPLE_CONNECT; endproperty
  property p_wake_pulse; WAKE |=> !WAKE; endproperty
  property p_wake_sleep; WAKE |-> $past(SLEEP_REQ, 2) || $past(SLEEP_REQ, 3) || $past(SLEEP_REQ, 4); endproperty
  property p_osc_sleep_off; s_osc_sleep |-> !ANALOG_POWER; endproperty
  property p_chs_copy; s_wr_ctrl0 |-> ##2 CHANNEL_SELECT == chs_ff; endproperty
  a_wait_state: assert property (p_wait_state) else $error("access not answered after one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_err_qual: assert property (p_err_qual) else $error("slave error without ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside ready");
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
  a_hold_min: assert property (p_hold_min) else $error("capacitor reconnected too soon");
  a_no_sample_unpowered: assert property (p_no_sample_unpowered) else $error("sampling while unpowered");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
  a_osc_sleep_off: assert property (p_osc_sleep_off) else $error("powered in sleep on osc clock");
  a_chs_copy: assert property (p_chs_copy) else $error("channel select not driven");
endmodule

bind adcseq_top adcseq_monitor u_mon (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SLEEP_REQ(SLEEP_REQ), .WAKE(WAKE), .CHANNEL_SELECT(CHANNEL_SELECT), .SAMPLE_CONNECT(SAMPLE_CONNECT),
  .ANALOG_POWER(ANALOG_POWER), .DAC_CODE(DAC_CODE));

// File: verification/adcseq_analog_model.sv
/*
  adcseq_analog_model: comparator and free-running internal rc clock.
  assumes: level is the input in steps; it sits half a step above it.
*/
`timescale 1ns/1ps
module adcseq_analog_model #(
  parameter int RC_HALF = 40
) (
  // clock
  input wire logic clk,
  // trial code and input level
  input wire logic [9:0] dac_code,
  input wire logic [9:0] level,
  // answers
  output logic comp_high,
  output logic rc_clk
);
  int rc_cnt = 0;
  initial begin
    comp_high = 1'b0;
    rc_clk = 1'b0;
  end
  // half-step offset so no trial ever ties with the input
  always @(posedge clk) begin
    comp_high <= {level, 1'b1} > {dac_code, 1'b0};
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc_clk <= ~rc_clk;
  end
endmodule

// File: verification/tb.sv
/*
  tb: register-level tests of adcseq_top with an analog partner model.
  assumes: 50 MHz clock; rc bit period of 1.6 us from the model.
*/
`timescale 1ns/1ps
module tb;
  import adcseq_pkg::*;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  localparam int RC_TAD = 80;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [15:0] pins = 16'hffff;
  logic [9:0] level = 10'h000; // analog pins stay inputs
  logic last_err;
  wire [31:0] prdata;
  wire pready, pslverr, wake, comp, rc, sample, power;
  wire [3:0] chs;
  wire [9:0] dac;
  int err_count = 0, num_checks = 0, cyc = 0, wakes = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(posedge ref_clk) if (wake === 1'b1) wakes <= wakes + 1;
  adcseq_top u_dut (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLEEP_REQ(sleep_req), .PORT_PIN_LEVEL(pins), .RC_CLK_PIN(rc), .WAKE(wake), .COMPARATOR_HIGH(comp),
    .CHANNEL_SELECT(chs), .SAMPLE_CONNECT(sample), .ANALOG_POWER(power), .DAC_CODE(dac));
  adcseq_analog_model #(.RC_HALF(RC_TAD / 2)) u_ana (.clk(ref_clk), .dac_code(dac), .level(level),
    .comp_high(comp), .rc_clk(rc));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic start(input logic [1:0] cs, input logic just, input logic irq);
    int n;
    n = 0;
    apb(1'b1, ADCSEQ_CTRL1_OFS, 32'({cs, just, 5'h0}));
    apb(1'b1, ADCSEQ_FLAG_OFS, 32'({irq, 1'b0}));
    apb(1'b1, ADCSEQ_CTRL0_OFS, 32'h31);
    // go is refused during the hold after the last run; wait for acquisition
    while (sample !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) chk(32'h0, 32'h1);
    apb(1'b1, ADCSEQ_CTRL0_OFS, 32'h35);
  endtask
  task automatic conv(input logic [1:0] cs, input logic just, input logic [9:0] v);
    int t0, tad, e;
    tad = cs == ADCSEQ_CS_DIV8 ? ADCSEQ_TOSC_DIV8 : cs == ADCSEQ_CS_DIV32 ? ADCSEQ_TOSC_DIV32 :
          cs == ADCSEQ_CS_DIV64 ? ADCSEQ_TOSC_DIV64 : RC_TAD;
    level <= v;
    start(cs, just, 1'b0);
    t0 = cyc;
    do apb(1'b0, ADCSEQ_CTRL0_OFS, 32'h0); while (q[ADCSEQ_GO_BIT] === 1'b1 && cyc - t0 < 2000);
    e = cyc - t0;
    chk(32'(e >= 10 * tad + 4 && e <= 13 * tad + 12), 32'h1);
    rd(ADCSEQ_FLAG_OFS, 32'h1, 32'h1);
    rd(ADCSEQ_RESH_OFS, just ? 32'(v[9:8]) : 32'(v[9:2]));
    rd(ADCSEQ_RESL_OFS, just ? 32'(v[7:0]) : 32'({v[1:0], 6'h0}));
  endtask
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int n, w0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADCSEQ_CTRL0_OFS, 32'(ADCSEQ_CTRL0_RST));
    rd(ADCSEQ_CTRL1_OFS, 32'(ADCSEQ_CTRL1_RST));
    rd(ADCSEQ_FLAG_OFS, 32'h0);
    rd(8'h18, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    apb(1'b1, ADCSEQ_RESL_OFS, 32'h5a);
    apb(1'b1, ADCSEQ_RESH_OFS, 32'ha5);
    rd(ADCSEQ_RESL_OFS, 32'h5a);
    rd(ADCSEQ_RESH_OFS, 32'ha5);
    rd(ADCSEQ_PORT_OFS, 32'h0);
    apb(1'b1, ADCSEQ_CTRL1_OFS, 32'he);
    rd(ADCSEQ_PORT_OFS, 32'hffff);
    apb(1'b1, ADCSEQ_CTRL0_OFS, 32'h4);
    rd(ADCSEQ_CTRL0_OFS, 32'h0);
    for (int i = 0; i < 4; i++) conv(2'(i), i[0], 10'h2a5 ^ 10'(i * 37));
    conv(ADCSEQ_CS_DIV8, 1'b0, 10'h000);
    conv(ADCSEQ_CS_DIV8, 1'b1, 10'h3ff);
    // abort mid-run: old result must survive
    level <= 10'h1c3;
    start(ADCSEQ_CS_DIV32, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b1, ADCSEQ_CTRL0_OFS, 32'h31);
    n = 0;
    while (sample !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(n >= 30 && n <= 72), 32'h1);
    rd(ADCSEQ_CTRL0_OFS, 32'h31);
    rd(ADCSEQ_RESL_OFS, 32'hff);
    rd(ADCSEQ_FLAG_OFS, 32'h0, 32'h1);
    // sleep on the oscillator clock aborts and powers down
    start(ADCSEQ_CS_DIV64, 1'b1, 1'b0);
    repeat (30) @(posedge ref_clk);
    sleep_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, power}, 32'h0);
    rd(ADCSEQ_CTRL0_OFS, 32'h1, 32'h1);
    sleep_req <= 1'b0;
    rd(ADCSEQ_RESH_OFS, 32'h3);
    // sleep on the rc clock with wake enabled
    level <= 10'h0f0;
    start(ADCSEQ_CS_RC, 1'b1, 1'b1);
    sleep_req <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 1500) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, wake}, 32'h1);
    sleep_req <= 1'b0;
    rd(ADCSEQ_RESL_OFS, 32'hf0);
    // without wake enable the converter only powers down
    level <= 10'h20f;
    w0 = wakes;
    start(ADCSEQ_CS_RC, 1'b1, 1'b0);
    sleep_req <= 1'b1;
    n = 0;
    while (power !== 1'b0 && n < 1500) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(n > 10 * RC_TAD && n < 1500), 32'h1);
    rd(ADCSEQ_CTRL0_OFS, 32'h1, 32'h5);
    rd(ADCSEQ_RESH_OFS, 32'h2);
    chk(32'(wakes), 32'(w0));
    sleep_req <= 1'b0;
    // reset in mid conversion
    start(ADCSEQ_CS_DIV64, 1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADCSEQ_CTRL0_OFS, 32'h0);
    chk({31'h0, power}, 32'h0);
    end_sim;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    end_sim;
  end
endmodule
